// [hw/xor_dir_pkg.sv]
// Package: opcode fields, carriers and reset values for the XOR / direction-load decoder
package xor_dir_pkg;
    localparam int          INSTR_W         = 12;
    localparam int          DATA_W          = 8;
    localparam int          FADDR_W         = 5;
    // Direction-load: 0000 0000 0fff, only f = 6 is a valid port
    localparam logic [8:0]  DIR_LOAD_MATCH  = 9'h000;
    localparam int          DIR_LOAD_TOP    = 11;
    localparam int          DIR_LOAD_BOT    = 3;
    localparam logic [2:0]  DIR_PORT_SEL    = 3'h6;
    // Literal XOR: 1111 kkkk kkkk
    localparam logic [3:0]  XOR_LIT_MATCH   = 4'hF;
    localparam int          LIT_OP_BOT      = 8;
    localparam int          REG_OP_BOT      = 6;
    // Register XOR: 0001 10df ffff
    localparam logic [5:0]  XOR_REG_MATCH   = 6'h06;
    localparam int          DEST_BIT        = 5;
    // Reset values
    localparam logic [7:0]  ACC_RESET       = 8'h00;
    localparam logic [7:0]  DIR_RESET       = 8'hFF;

    // One fetched instruction
    typedef struct packed {
        logic               valid;
        logic [11:0]        word;
    } instr_t;

    // Write port into the file register array
    typedef struct packed {
        logic               en;
        logic [4:0]         addr;
        logic [7:0]         data;
    } file_wr_t;

    // Zero-flag update request
    typedef struct packed {
        logic               en;
        logic               value;
    } zflag_t;
endpackage

// [hw/xor_and_direction_load_exec.sv]
// Decode and single-cycle execute of direction-load, literal XOR and register XOR
// Operation
// - The direction-load opcode with f equal to 6 copies the accumulator into that port's direction register in one cycle and touches no status flag.
// - The literal XOR opcode exclusive-ORs the accumulator with the 8-bit literal in one cycle.
// - The literal XOR result goes only to the accumulator.
// - The register XOR opcode exclusive-ORs the accumulator with the addressed file register (0 to 31) in one cycle.
// - With destination bit 0 the register XOR result goes to the accumulator and the file register is left alone.
// - With destination bit 1 the register XOR result goes to the file register and the accumulator is left alone.
`timescale 1ns/100ps
module xor_and_direction_load_exec (
    input  wire logic                core_clk,
    input  wire logic                arst_n,
    input  wire xor_dir_pkg::instr_t instr,
    input  wire logic [7:0]          file_rd_data,
    output logic [4:0]               file_rd_addr,
    output xor_dir_pkg::file_wr_t    file_wr,
    output xor_dir_pkg::zflag_t      zflag,
    output logic [7:0]               acc,
    output logic [7:0]               second_io_port_dir,
    output logic                     handled
);
    import xor_dir_pkg::*;

    // Decoded instruction class, at most one of the first three is high; is_xor_any follows either XOR
    logic                is_dir_load;
    logic                is_xor_lit;
    logic                is_xor_reg;
    logic                is_xor_any;

    // Register XOR destination, high selects the file register
    logic                dest_file;

    // Operand, result and zero test of whichever XOR is active
    logic [7:0]          operand;
    logic [7:0]          result;
    logic                result_zero;

    // Accumulator
    logic [7:0]          acc_q;
    logic [7:0]          acc_d;

    // Direction latch of the second port
    logic [7:0]          dir_q;
    logic [7:0]          dir_d;

    // Registered writeback into the file register array
    file_wr_t            file_wr_q;
    file_wr_t            file_wr_d;

    // Registered zero-flag update for the status register
    zflag_t              zflag_q;
    zflag_t              zflag_d;

    // Opcode decode
    always_comb begin
        // only port 6 is a legal target
        is_dir_load = instr.valid
                      && instr.word[DIR_LOAD_TOP:DIR_LOAD_BOT] == DIR_LOAD_MATCH
                      && instr.word[2:0] == DIR_PORT_SEL;
        is_xor_lit  = instr.valid
                      && instr.word[INSTR_W-1:LIT_OP_BOT] == XOR_LIT_MATCH;
        is_xor_reg  = instr.valid
                      && instr.word[INSTR_W-1:REG_OP_BOT] == XOR_REG_MATCH;
        is_xor_any  = is_xor_lit | is_xor_reg;
        dest_file   = instr.word[DEST_BIT];
    end

    // Register read address comes straight from the opcode
    assign file_rd_addr = instr.word[FADDR_W-1:0];

    // Refused opcodes leave this low and change nothing
    assign handled      = is_dir_load | is_xor_lit | is_xor_reg;

    // Second operand: literal field or the addressed file register
    always_comb begin
        operand = 8'h00;
        if (is_xor_lit) begin
            operand = instr.word[DATA_W-1:0];
        end else if (is_xor_reg) begin
            operand = file_rd_data;
        end
    end

    // Shared exclusive-OR, one cycle from the accumulator
    always_comb begin
        result      = acc_q ^ operand;
        result_zero = (result == 8'h00);
    end

    // Accumulator next value
    always_comb begin
        acc_d = acc_q;
        if (is_xor_lit) begin
            acc_d = result;
        end else if (is_xor_reg && !dest_file) begin
            acc_d = result;
        end
        // destination bit 1 keeps the accumulator
    end

    // Accumulator register
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_q <= ACC_RESET;
        end else begin
            acc_q <= acc_d;
        end
    end

    // Direction latch next value
    always_comb begin
        dir_d = dir_q;
        if (is_dir_load) begin
            dir_d = acc_q;
        end
    end

    // Direction latch register, all pins inputs after reset
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            dir_q <= DIR_RESET;
        end else begin
            dir_q <= dir_d;
        end
    end

    // Writeback next value, a one-cycle strobe
    always_comb begin
        file_wr_d = '0;
        if (is_xor_reg && dest_file) begin
            // result back into the addressed register
            file_wr_d.en   = 1'b1;
            file_wr_d.addr = instr.word[FADDR_W-1:0];
            file_wr_d.data = result;
        end
        // the literal XOR never raises the strobe
    end

    // Writeback register; the array sees the write one cycle late
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            file_wr_q <= '0;
        end else begin
            file_wr_q <= file_wr_d;
        end
    end

    // Zero-flag next value, a one-cycle strobe
    always_comb begin
        zflag_d = '0;
        if (is_xor_any) begin
            zflag_d.en    = 1'b1;
            zflag_d.value = result_zero;
        end
    end

    // Zero-flag register
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            zflag_q <= '0;
        end else begin
            zflag_q <= zflag_d;
        end
    end

    // Registered outputs
    assign acc                = acc_q;
    assign second_io_port_dir = dir_q;
    assign file_wr            = file_wr_q;
    assign zflag              = zflag_q;

    // Hazard: a register XOR that writes back and an immediately following
    // read of the same register sees the old value, because the array
    // takes the write one edge after the instruction edge.
    // Callers that need the new value leave one cycle between them.

    // Limitation: only the second port has a direction latch here;
    // any other port number is refused and handled stays low.

    // Limitation: the zero flag is delivered as an update strobe only;
    // the status register outside keeps its value when the strobe is low.

    // Trade-off: the operand multiplexer is shared by both XOR forms,
    // which saves one eight-bit XOR at the cost of one mux level.

    // Note: nothing here depends on the instruction word when valid is low,
    // except the read address, which the array may use freely.

    // Note: reset values leave every port pin an input and the
    // accumulator clear, so a fresh core drives nothing out.
endmodule

// [test/xor_exec_props.sv]
// Checker: port-level properties of the XOR and direction-load executor
`timescale 1ns/100ps
module xor_exec_props (
    input logic                  core_clk,
    input logic                  arst_n,
    input xor_dir_pkg::instr_t   instr,
    input logic [7:0]            file_rd_data,
    input logic [4:0]            file_rd_addr,
    input xor_dir_pkg::file_wr_t file_wr,
    input xor_dir_pkg::zflag_t   zflag,
    input logic [7:0]            acc,
    input logic [7:0]            second_io_port_dir,
    input logic                  handled
);
    import xor_dir_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // Opcode decodes
    wire lit = instr.valid && instr.word[11:8] == 4'hF;
    wire rx  = instr.valid && instr.word[11:6] == 6'h06;
    wire dir = instr.valid && instr.word[11:0] == 12'h006;
    property p_dir; dir |=> second_io_port_dir == $past(acc) && !zflag.en; endproperty
    a_dir: assert property (p_dir) else $error("direction load wrong");
    property p_lit; lit |=> acc == ($past(acc) ^ $past(instr.word[7:0])); endproperty
    a_lit: assert property (p_lit) else $error("literal xor wrong");
    property p_lit_nowr; lit |=> !file_wr.en; endproperty
    a_lit_nowr: assert property (p_lit_nowr) else $error("literal xor wrote file");
    property p_addr; rx |-> file_rd_addr == instr.word[4:0]; endproperty
    a_addr: assert property (p_addr) else $error("file address wrong");
    property p_d0; rx && !instr.word[5] |=> !file_wr.en && acc == ($past(acc) ^ $past(file_rd_data)); endproperty
    a_d0: assert property (p_d0) else $error("xor to acc wrong");
    property p_d1; rx && instr.word[5] |=> $stable(acc) && file_wr == {1'b1, $past(instr.word[4:0]), $past(acc) ^ $past(file_rd_data)}; endproperty
    a_d1: assert property (p_d1) else $error("xor to file wrong");
    property p_zen; lit || rx |=> zflag.en; endproperty
    a_zen: assert property (p_zen) else $error("zero flag not updated");
    property p_zval; zflag.en |-> zflag.value == (file_wr.en ? file_wr.data == 8'h00 : acc == 8'h00); endproperty
    a_zval: assert property (p_zval) else $error("zero flag value wrong");
    property p_hnd; handled == (lit || rx || dir); endproperty
    a_hnd: assert property (p_hnd) else $error("handled decode wrong");
endmodule
bind xor_and_direction_load_exec xor_exec_props xor_exec_props_i (.*);

// [test/file_reg_model.sv]
// Partner: file register array with combinational read and clocked write
`timescale 1ns/100ps
module file_reg_model (
    input  logic                  core_clk,
    input  logic [4:0]            file_rd_addr,
    input  xor_dir_pkg::file_wr_t file_wr,
    output logic [7:0]            file_rd_data
);
    logic [7:0] mem_q [32];
    // Known preload: register i holds A0 xor i
    initial for (int i = 0; i < 32; i++) mem_q[i] = 8'hA0 ^ 8'(i);
    always @(posedge core_clk) if (file_wr.en) mem_q[file_wr.addr] <= file_wr.data;
    assign file_rd_data = mem_q[file_rd_addr];
endmodule

// [test/xor_and_direction_load_exec_tb.sv]
// Testbench: directed checks of XOR and direction-load execution
`timescale 1ns/100ps
module xor_and_direction_load_exec_tb;
    import xor_dir_pkg::*;
    logic core_clk = 0, arst_n = 0;
    instr_t instr = '0;
    logic [7:0] file_rd_data, acc, second_io_port_dir;
    logic [4:0] file_rd_addr;
    logic handled;
    file_wr_t file_wr;
    zflag_t zflag;
    int err_count = 0, check_count = 0;
    xor_and_direction_load_exec xor_and_direction_load_exec_i (.core_clk(core_clk), .arst_n(arst_n),
        .instr(instr), .file_rd_data(file_rd_data), .file_rd_addr(file_rd_addr), .file_wr(file_wr),
        .zflag(zflag), .acc(acc), .second_io_port_dir(second_io_port_dir), .handled(handled));
    file_reg_model file_reg_model_i (.core_clk(core_clk), .file_rd_addr(file_rd_addr),
        .file_wr(file_wr), .file_rd_data(file_rd_data));
    initial forever #5 core_clk = ~core_clk;
    task chk(input logic [23:0] got, input logic [23:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One instruction for one cycle, results seen at the following falling edge
    task run(input logic [11:0] w);
        @(negedge core_clk) instr = {1'b1, w};
        @(negedge core_clk) instr = '0;
    endtask
    task t_lit;
        run(12'hFB5); chk(acc, 8'hB5);
        run(12'hFAF); chk({zflag, file_wr.en, acc}, {3'b100, 8'h1A});
        run(12'hF1A); chk({zflag, file_wr.en, acc}, {3'b110, 8'h00});
    endtask
    task t_reg;
        run(12'hFB5);
        run(12'h1A5); chk({file_wr, acc}, {1'b1, 5'h05, 8'h10, 8'hB5});
        run(12'h185); chk({file_wr.en, zflag, acc}, {3'b010, 8'hA5});
    endtask
    task t_dir;
        run(12'h007); chk(second_io_port_dir, 8'hFF);
        run(12'h006); chk({zflag.en, second_io_port_dir}, {1'b0, 8'hA5});
    endtask
    // Refused and accepted opcodes as seen on handled, before the edge
    task t_hnd;
        @(negedge core_clk) instr = {1'b1, 12'h007};
        #1 chk(handled, 1'b0);
        @(negedge core_clk) instr = {1'b0, 12'h006};
        #1 chk(handled, 1'b0);
        @(negedge core_clk) instr = {1'b1, 12'hF00};
        #1 chk(handled, 1'b1);
        @(negedge core_clk) instr = '0;
        chk(acc, 8'hA5);
    endtask
    // Mid-run reset, then two XORs back to back after one idle cycle following release
    task t_rst;
        @(negedge core_clk) arst_n = 0;
        @(negedge core_clk) chk({file_wr, zflag, second_io_port_dir, acc}, {16'h0000, 8'hFF, 8'h00});
        arst_n = 1;
        @(negedge core_clk) instr = {1'b1, 12'hFFF};
        @(negedge core_clk) instr = {1'b1, 12'hFFF};
        @(negedge core_clk) instr = '0;
        chk({zflag, acc}, {2'b11, 8'h00});
    endtask
    task complete_run;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #2000 err_count++;
        complete_run();
    end
    initial begin
        repeat (4) @(negedge core_clk);
        arst_n = 1;
        t_lit();
        t_reg();
        t_dir();
        t_hnd();
        t_rst();
        complete_run();
    end
endmodule
